// file: bench/conv_partner.sv
// Converter and PWM output stage model facing the sequencer.
// Assumes the design's clock and reset.
`timescale 1ns/1ps
`default_nettype none
module conv_partner #(
    parameter int PERIOD = 400,
    parameter int ON_LEN = 300
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    // Converter
    input  wire logic [4:0]  muxSel,
    input  wire logic        convStart,
    output logic             convDone,
    output logic [7:0]       convData,
    // Output stage
    output logic [23:0]      outOn,
    output logic             dimCycleStart
);
    int         phase_q;
    int         wait_q;
    logic       busy_q;
    logic [7:0] val_q;
    // Stale data shows inverted so a late sample cannot match
    assign convData = convDone ? val_q : ~val_q;
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            phase_q       <= 0;
            wait_q        <= 0;
            busy_q        <= 1'b0;
            val_q         <= 8'h00;
            convDone      <= 1'b0;
            outOn         <= 24'h000000;
            dimCycleStart <= 1'b0;
        end else begin
            phase_q       <= (phase_q == PERIOD - 1) ? 0 : phase_q + 1;
            dimCycleStart <= (phase_q == PERIOD - 1);
            // On pulse well above blank plus three conversions
            outOn    <= (phase_q >= 3 && phase_q < ON_LEN) ? '1 : '0;
            convDone <= 1'b0;
            if (convStart) begin
                busy_q <= 1'b1;
                wait_q <= $urandom_range(40, 2);
                val_q  <= (8'(muxSel) * 8'h07) ^ 8'h5A;
            end else if (busy_q && wait_q == 0) begin
                busy_q   <= 1'b0;
                convDone <= 1'b1;
            end else if (busy_q) begin
                wait_q <= wait_q - 1;
            end
        end
    end
endmodule : conv_partner
`default_nettype wire

// file: bench/test_adc_sequencer.sv
// Self-checking bench of the diagnostic converter sequencer.
// Assumes conv_partner as converter and output stage; bench is bus master.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin errTotal++; \
    $display("FAIL %s expected %0h seen %0h", nm, e, g); end end
module test_adc_sequencer;
    logic        clk_sys, reset_n, hsel, hwrite, hreadyout, hresp;
    logic        convStart, convDone, dimCycleStart;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [4:0]  muxSel, code;
    logic [7:0]  convData;
    logic [23:0] outOn, en;
    int          errTotal, comparisons, dimCnt, mark;

    adc_sequencer i_adc_sequencer (
        .clk_sys, .reset_n, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite,
        .hsize(adc_seq_pkg::SIZE_WORD), .hwdata, .hready(hreadyout), .hreadyout,
        .hresp, .hrdata, .outOn, .dimCycleStart, .muxSel, .convStart,
        .convDone, .convData
    );
    conv_partner i_conv_partner (
        .clk_sys, .reset_n, .muxSel, .convStart, .convDone, .convData,
        .outOn, .dimCycleStart
    );

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (dimCycleStart === 1'b1) dimCnt <= dimCnt + 1;
    end
////////////////////////////////////////////////////////////
    task automatic wrap_up(input int hang);
        errTotal += hang;
        $display("Comparisons %0d, mismatches %0d", comparisons, errTotal);
        if (errTotal == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : wrap_up
    task automatic edgeRdy();
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) wrap_up(1);
    endtask : edgeRdy
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        edgeRdy();
        htrans <= 2'h0;
        hwdata <= d;
        edgeRdy();
        rd = hrdata;
    endtask : bus
    // Status reads have no side effect, so polling is safe
    task automatic pollStat(input int b);
        int n;
        n = 0;
        do begin
            bus(1'b0, adc_seq_pkg::ADDR_STATUS, 32'h0);
            n++;
        end while (rd[b] !== 1'b1 && n < 9000);
        if (n >= 9000) wrap_up(1);
    endtask : pollStat
    function automatic logic [7:0] expConv(input logic [4:0] c);
        return (8'(c) * 8'h07) ^ 8'h5A;
    endfunction : expConv
    function automatic logic [7:0] expPeak(input logic [23:0] e);
        logic [7:0] m;
        m = 8'h00;
        for (int i = 0; i < 24; i++) begin
            if (e[i] && expConv(5'(8 + i)) > m) m = expConv(5'(8 + i));
        end
        return m;
    endfunction : expPeak
////////////////////////////////////////////////////////////
    initial begin
        reset_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        hwrite = 1'b0;
        htrans = 2'h0;
        hwdata = 32'h0;
        errTotal = 0;
        comparisons = 0;
        dimCnt = 0;
        void'($urandom(32'h70df835c));
        repeat (8) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        // Result read skipped: it would start a conversion
        for (int i = 0; i < 7; i++) begin
            if (i != 2) begin
                bus(1'b0, 8'(i * 4), 32'h0);
                `CHK("reset read", 32'h0, rd)
                `CHK("okay response", 1'b0, hresp)
            end
        end
        bus(1'b1, adc_seq_pkg::ADDR_BLANK_CFG, '1);
        bus(1'b0, adc_seq_pkg::ADDR_BLANK_CFG, 32'h0);
        `CHK("blank width", 32'h0000000F, rd)
        bus(1'b1, adc_seq_pkg::ADDR_BLANK_CFG, 32'($urandom_range(2, 0)));
        en = 24'($urandom()) | 24'h000001;
        bus(1'b1, adc_seq_pkg::ADDR_OUT_ENABLE, 32'(en));
        $display("register test over");
        for (int i = 0; i < 12; i++) begin
            code = (i < 6) ? 5'(i) : (i == 6) ? 5'h07 : 5'(8 + $urandom_range(23));
            bus(1'b1, adc_seq_pkg::ADDR_CHAN_SELECT, 32'(code));
            bus(1'b0, adc_seq_pkg::ADDR_STATUS, 32'h0);
            `CHK("done after select", 1'b0, rd[0])
            pollStat(adc_seq_pkg::STAT_DONE_BIT);
            bus(1'b0, adc_seq_pkg::ADDR_RESULT, 32'h0);
            `CHK("manual result", 32'(expConv(code)), rd)
            bus(1'b0, adc_seq_pkg::ADDR_STATUS, 32'h0);
            `CHK("done after read", 1'b0, rd[0])
        end
        $display("manual test over");
        mark = dimCnt;
        bus(1'b1, adc_seq_pkg::ADDR_CHAN_SELECT, 32'(adc_seq_pkg::CODE_PEAK));
        pollStat(adc_seq_pkg::STAT_DONE_BIT);
        `CHK("scan length", 1'b1, dimCnt - mark >= 10)
        for (int k = 0; k < 2; k++) begin
            `CHK("scan halted", 1'b0, rd[adc_seq_pkg::STAT_BUSY_BIT])
            bus(1'b0, adc_seq_pkg::ADDR_RESULT, 32'h0);
            `CHK("peak result", 32'(expPeak(en)), rd)
            if (k == 0) pollStat(adc_seq_pkg::STAT_DONE_BIT);
        end
        $display("scan test over");
        // Longest blank makes the period too short; host keeps partial duty on purpose
        bus(1'b1, adc_seq_pkg::ADDR_BLANK_CFG, 32'hF);
        bus(1'b1, adc_seq_pkg::ADDR_CHAN_SELECT, 32'h1);
        pollStat(adc_seq_pkg::STAT_ERR_BIT);
        `CHK("aborted done", 1'b0, rd[0])
        for (int v = 0; v < 2; v++) begin
            bus(1'b1, adc_seq_pkg::ADDR_FAULT_CLEAR, 32'(v));
            bus(1'b0, adc_seq_pkg::ADDR_STATUS, 32'h0);
            `CHK("error flag", 1'(1 - v), rd[adc_seq_pkg::STAT_ERR_BIT])
        end
        $display("error test over");
        wrap_up(0);
    end
endmodule : test_adc_sequencer
`default_nettype wire

// file: rtl/adc_seq_pkg.sv
// Constants, register map and state codes of the diagnostic converter sequencer.
// Assumes a 40 MHz core clock and a 32-bit AHB-Lite register port.
package adc_seq_pkg;

    // Register byte offsets
    localparam logic [7:0] ADDR_CHAN_SELECT = 8'h00;
    localparam logic [7:0] ADDR_BLANK_CFG   = 8'h04;
    localparam logic [7:0] ADDR_RESULT      = 8'h08;
    localparam logic [7:0] ADDR_STATUS      = 8'h0C;
    localparam logic [7:0] ADDR_FAULT_CLEAR = 8'h10;
    localparam logic [7:0] ADDR_OUT_ENABLE  = 8'h14;

    // Field widths and positions
    localparam int SEL_W    = 5;
    localparam int BLANK_W  = 4;
    localparam int RES_W    = 8;
    localparam int NUM_OUT  = 24;
    localparam int CYC_W    = 16;
    localparam int STAT_DONE_BIT    = 0;
    localparam int STAT_ERR_BIT     = 1;
    localparam int STAT_BUSY_BIT    = 2;
    localparam int FAULT_CLEAR_BIT  = 0;

    // Reset values
    localparam logic [4:0]  CHSEL_RST  = 5'h00;
    localparam logic [3:0]  BLANK_RST  = 4'h0;
    localparam logic [23:0] ENABLE_RST = 24'h000000;

    // Channel codes
    localparam logic [4:0] CODE_PEAK      = 5'h06;
    localparam logic [4:0] CODE_OUT_FIRST = 5'h08;
    localparam logic [2:0] GROUP_LAST     = 3'h7;

    // Bus encodings
    localparam logic [2:0] SIZE_WORD = 3'h2;

    // Timing
    localparam int CLK_PERIOD_NS  = 25;
    localparam int CONV_TIME_NS   = 1000;
    localparam int BLANK_STEP_NS  = 1000;
    localparam int CONV_CYC =
        (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BLANK_STEP_CYC =
        (BLANK_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_COUNT = 3;
    // Dimming starts seen before the first group; makes nine full periods
    localparam logic [3:0] SCAN_LEAD = 4'h2;
    localparam logic [3:0] SCAN_MIN_STARTS = 4'hA;

    typedef enum logic [2:0] {
        S_IDLE    = 3'b000,
        S_ARM     = 3'b001,
        S_WAIT_ON = 3'b010,
        S_BLANK   = 3'b011,
        S_CONV    = 3'b100
    } seq_state_t;

endpackage : adc_seq_pkg

// file: rtl/adc_sequencer.sv
// Diagnostic converter sequencer: channel select, blanking, auto peak scan.
// Assumes an AHB-Lite master, PWM and converter logic on clk_sys.
// Overview of operation
// - Codes 08h to 1Fh select output voltages A0 through H2 in order.
// - Enabled output is sampled only after the blanking delay after turn-on.
// - Disabled output is sampled in its off state without blanking wait.
// - Code 06h starts auto scan storing the peak output voltage.
// - Auto scan result is ready no sooner than nine full PWM cycles.
// - Auto scan measures one group of three per dimming cycle, eight groups.
// - After all eight groups the done flag sets and scanning stops.
// - Result read clears done and restarts scan if code is still 06h.
// - Channel select write clears done and conversion restarts.
// - Auto scan skips disabled outputs and excludes them from the peak.
// - Each start compares dimming period with blanking plus three conversions.
// - Too short period aborts the measurement and sets the error flag.
// - Error flag clears only when host writes 1 to fault clear.
// - Faults are only reported through flags, no autonomous action here.
// - Manual conversion per select write stores 8-bit result and sets done.
// - Channel select is a 5-bit field, codes 00h-07h internal.
//
// Design decisions made here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module adc_sequencer (
    // Clock, reset, enable
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        ce,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Output stage state
    input  wire logic [23:0] outOn,
    input  wire logic        dimCycleStart,
    // Converter
    output logic [4:0]       muxSel,
    output logic             convStart,
    input  wire logic        convDone,
    input  wire logic [7:0]  convData
);

    ////////////////////////////////////////////////////////////////////////////
    // Functions

    function automatic logic [4:0] groupBase(input logic [2:0] g);
        groupBase = 5'({g, 1'b0}) + 5'(g);
    endfunction : groupBase

    function automatic logic [4:0] chanCode(input logic [2:0] g,
                                            input logic [1:0] s);
        chanCode = adc_seq_pkg::CODE_OUT_FIRST + groupBase(g) + 5'(s);
    endfunction : chanCode

    // Lowest enabled slot at or above from; bit 2 flags a hit
    function automatic logic [2:0] pickSlot(input logic [2:0] mask,
                                            input logic [2:0] from);
        pickSlot = 3'h0;
        for (int i = 2; i >= 0; i--) begin
            if (mask[i] && 3'(i) >= from) begin
                pickSlot = {1'b1, 2'(i)};
            end
        end
    endfunction : pickSlot

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    adc_seq_pkg::seq_state_t stateQ, stateD;
    logic [4:0]  chselQ;
    logic [3:0]  blankSetQ;
    logic [23:0] enableQ;
    logic [7:0]  resultQ, resultD;
    logic [7:0]  peakQ, peakD;
    logic        doneQ, errQ;
    logic        autoQ, autoD;
    logic [2:0]  groupQ, groupD;
    logic [1:0]  slotQ, slotD;
    logic [15:0] cntQ, cntD;
    logic [3:0]  seenQ, seenD;
    logic [23:0] outOnQ;
    logic        setDone, setErr, enterConv;
    logic [7:0]  dAddrQ;
    logic        dWriteQ, dValidQ;
    logic [15:0] period;
    logic        periodValid;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode

    wire       addrPhase = hsel && htrans[1] && hready && ce;
    wire [7:0] aLow      = haddr[7:0];
    wire       wrOn      = dValidQ && dWriteQ && ce;
    wire       wrChsel   = wrOn && dAddrQ == adc_seq_pkg::ADDR_CHAN_SELECT;
    wire       wrBlank   = wrOn && dAddrQ == adc_seq_pkg::ADDR_BLANK_CFG;
    wire       wrEnable  = wrOn && dAddrQ == adc_seq_pkg::ADDR_OUT_ENABLE;
    wire       faultClr  = wrOn && dAddrQ == adc_seq_pkg::ADDR_FAULT_CLEAR
                           && hwdata[adc_seq_pkg::FAULT_CLEAR_BIT];
    wire       rdResult  = addrPhase && !hwrite
                           && aLow == adc_seq_pkg::ADDR_RESULT;
    wire       startEv   = wrChsel || rdResult;
    wire       busy      = stateQ != adc_seq_pkg::S_IDLE;

    wire [31:0] statusWord =
        32'({busy, errQ, doneQ});
    wire [31:0] readWord =
        aLow == adc_seq_pkg::ADDR_CHAN_SELECT ? 32'(chselQ)   :
        aLow == adc_seq_pkg::ADDR_BLANK_CFG   ? 32'(blankSetQ) :
        aLow == adc_seq_pkg::ADDR_RESULT      ? 32'(resultQ)   :
        aLow == adc_seq_pkg::ADDR_STATUS      ? statusWord     :
        aLow == adc_seq_pkg::ADDR_OUT_ENABLE  ? 32'(enableQ)   :
        32'h00000000;

    // Zero wait states; a low enable stretches the data phase
    assign hreadyout = ce;
    assign hresp     = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Channel and timing decode

    wire [4:0] selD     = wrChsel ? hwdata[4:0] : chselQ;
    wire       newIsOut = selD >= adc_seq_pkg::CODE_OUT_FIRST;
    wire [4:0] newIdx   = selD - adc_seq_pkg::CODE_OUT_FIRST;
    wire       manIsOut = chselQ >= adc_seq_pkg::CODE_OUT_FIRST;
    wire [4:0] manIdx   = chselQ - adc_seq_pkg::CODE_OUT_FIRST;
    wire [4:0] grpBase  = groupBase(groupQ);
    wire [2:0] grpMask  = enableQ[grpBase +: 3];
    wire [23:0] outRise = outOn & ~outOnQ;
    wire [2:0] grpRise  = outRise[grpBase +: 3] & grpMask;
    wire [2:0] firstPick = pickSlot(grpMask, 3'h0);
    wire [2:0] nextPick  = pickSlot(grpMask, 3'(slotQ) + 3'h1);
    wire       onRise   = autoQ ? |grpRise
                                : (manIsOut && outRise[manIdx]);
    wire [7:0] peakNew  = convData > peakQ ? convData : peakQ;

    wire [15:0] blankCyc = 16'(blankSetQ)
                           * 16'(adc_seq_pkg::BLANK_STEP_CYC);
    wire [15:0] needCyc  = blankCyc + 16'(adc_seq_pkg::CONV_COUNT
                           * adc_seq_pkg::CONV_CYC);
    // Unknown period is let through; the first period needs two starts
    wire        tooShort = periodValid && period < needCyc;

    dim_period_meter meter (
        .clk_sys       (clk_sys),
        .reset_n       (reset_n),
        .ce            (ce),
        .dimCycleStart (dimCycleStart),
        .period        (period),
        .periodValid   (periodValid)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    always_comb begin
        stateD    = stateQ;
        groupD    = groupQ;
        slotD     = slotQ;
        autoD     = autoQ;
        cntD      = cntQ;
        seenD     = seenQ;
        resultD   = resultQ;
        peakD     = peakQ;
        setDone   = 1'b0;
        setErr    = 1'b0;
        enterConv = 1'b0;
        unique case (stateQ)
            adc_seq_pkg::S_IDLE: begin
            end
            adc_seq_pkg::S_ARM: begin
                if (dimCycleStart) begin
                    seenD = &seenQ ? seenQ : seenQ + 4'h1;
                    if (seenQ >= adc_seq_pkg::SCAN_LEAD) begin
                        if (firstPick[2]) begin
                            stateD = adc_seq_pkg::S_WAIT_ON;
                        end else if (groupQ == adc_seq_pkg::GROUP_LAST) begin
                            resultD = peakQ;
                            setDone = 1'b1;
                            stateD  = adc_seq_pkg::S_IDLE;
                        end else begin
                            groupD = groupQ + 3'h1;
                        end
                    end
                end
            end
            adc_seq_pkg::S_WAIT_ON: begin
                if (onRise) begin
                    stateD = adc_seq_pkg::S_BLANK;
                    cntD   = blankCyc;
                    if (autoQ) begin
                        slotD = firstPick[1:0];
                    end
                end
            end
            adc_seq_pkg::S_BLANK: begin
                if (cntQ == 16'h0000) begin
                    stateD    = adc_seq_pkg::S_CONV;
                    enterConv = 1'b1;
                end else begin
                    cntD = cntQ - 16'h0001;
                end
            end
            adc_seq_pkg::S_CONV: begin
                if (convDone && !autoQ) begin
                    resultD = convData;
                    setDone = 1'b1;
                    stateD  = adc_seq_pkg::S_IDLE;
                end else if (convDone) begin
                    peakD = peakNew;
                    if (nextPick[2]) begin
                        slotD     = nextPick[1:0];
                        enterConv = 1'b1;
                    end else if (groupQ == adc_seq_pkg::GROUP_LAST) begin
                        resultD = peakNew;
                        setDone = 1'b1;
                        stateD  = adc_seq_pkg::S_IDLE;
                    end else begin
                        groupD = groupQ + 3'h1;
                        stateD = adc_seq_pkg::S_ARM;
                    end
                end
            end
            default: begin
                stateD = adc_seq_pkg::S_IDLE;
            end
        endcase
        if (startEv) begin
            seenD     = 4'h0;
            groupD    = 3'h0;
            slotD     = 2'h0;
            peakD     = 8'h00;
            enterConv = 1'b0;
            autoD     = selD == adc_seq_pkg::CODE_PEAK;
            if (tooShort) begin
                setErr = 1'b1;
                stateD = adc_seq_pkg::S_IDLE;
            end else if (autoD) begin
                stateD = adc_seq_pkg::S_ARM;
            end else if (newIsOut && enableQ[newIdx]) begin
                stateD = adc_seq_pkg::S_WAIT_ON;
            end else begin
                stateD    = adc_seq_pkg::S_CONV;
                enterConv = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            dAddrQ  <= 8'h00;
            dWriteQ <= 1'b0;
            dValidQ <= 1'b0;
            hrdata  <= 32'h00000000;
        end else if (ce) begin
            dValidQ <= addrPhase && hsize == adc_seq_pkg::SIZE_WORD;
            dAddrQ  <= aLow;
            dWriteQ <= hwrite;
            if (addrPhase && !hwrite) begin
                hrdata <= readWord;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            chselQ    <= adc_seq_pkg::CHSEL_RST;
            blankSetQ <= adc_seq_pkg::BLANK_RST;
            enableQ   <= adc_seq_pkg::ENABLE_RST;
        end else if (ce) begin
            chselQ <= selD;
            if (wrBlank) begin
                blankSetQ <= hwdata[adc_seq_pkg::BLANK_W-1:0];
            end
            if (wrEnable) begin
                enableQ <= hwdata[adc_seq_pkg::NUM_OUT-1:0];
            end
        end
    end

    // Flags: hardware set wins over a clear in the same cycle
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            doneQ <= 1'b0;
            errQ  <= 1'b0;
        end else if (ce) begin
            doneQ <= setDone || (doneQ && !startEv);
            errQ  <= setErr || (errQ && !faultClr);
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            stateQ    <= adc_seq_pkg::S_IDLE;
            groupQ    <= 3'h0;
            slotQ     <= 2'h0;
            autoQ     <= 1'b0;
            cntQ      <= 16'h0000;
            seenQ     <= 4'h0;
            resultQ   <= 8'h00;
            peakQ     <= 8'h00;
            outOnQ    <= 24'h000000;
            convStart <= 1'b0;
            muxSel    <= adc_seq_pkg::CHSEL_RST;
        end else if (ce) begin
            stateQ    <= stateD;
            groupQ    <= groupD;
            slotQ     <= slotD;
            autoQ     <= autoD;
            cntQ      <= cntD;
            seenQ     <= seenD;
            resultQ   <= resultD;
            peakQ     <= peakD;
            outOnQ    <= outOn;
            convStart <= enterConv;
            muxSel    <= autoD ? chanCode(groupD, slotD) : selD;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    chan_map_a: assert property (
        convStart && !autoQ |-> muxSel == chselQ)
        else $error("manual mux select differs from channel select");

    blank_wait_a: assert property (
        ce && !startEv && stateQ == adc_seq_pkg::S_WAIT_ON && onRise
        |=> stateQ == adc_seq_pkg::S_BLANK && cntQ == $past(blankCyc))
        else $error("blanking not loaded on output turn-on");

    blank_count_a: assert property (
        ce && !startEv && stateQ == adc_seq_pkg::S_BLANK && cntQ != 16'h0000
        |=> cntQ == $past(cntQ) - 16'h0001)
        else $error("blanking counter did not step down");

    off_state_a: assert property (
        ce && startEv && !tooShort && selD != adc_seq_pkg::CODE_PEAK
        && newIsOut && !enableQ[newIdx]
        |=> stateQ == adc_seq_pkg::S_CONV && convStart)
        else $error("disabled output did not convert at once");

    peak_mode_a: assert property (
        ce && startEv && !tooShort && selD == adc_seq_pkg::CODE_PEAK
        |=> autoQ && stateQ == adc_seq_pkg::S_ARM)
        else $error("peak code did not start auto scan");

    nine_cycles_a: assert property (
        ce && autoQ && setDone && !startEv
        |-> seenD >= adc_seq_pkg::SCAN_MIN_STARTS)
        else $error("auto scan finished too early");

    group_step_a: assert property (
        autoQ && stateQ == adc_seq_pkg::S_ARM
        ##1 stateQ == adc_seq_pkg::S_WAIT_ON |-> $past(dimCycleStart))
        else $error("group measured without a dimming start");

    scan_done_a: assert property (
        ce && autoQ && setDone && !startEv
        |=> doneQ && stateQ == adc_seq_pkg::S_IDLE)
        else $error("auto scan did not stop with done");

    read_clear_a: assert property (
        ce && rdResult && !setDone
        |=> !doneQ && (stateQ != adc_seq_pkg::S_IDLE || errQ))
        else $error("result read did not clear and restart");

    sel_clear_a: assert property (
        ce && wrChsel && !setDone
        |=> !doneQ && (stateQ != adc_seq_pkg::S_IDLE || errQ))
        else $error("select write did not clear and restart");

    skip_off_a: assert property (
        convStart && autoQ |-> enableQ[groupBase(groupQ) + 5'(slotQ)])
        else $error("disabled output converted in auto scan");

    too_short_a: assert property (
        ce && startEv && tooShort |=> errQ && stateQ == adc_seq_pkg::S_IDLE)
        else $error("short period did not abort with error");

    err_hold_a: assert property (
        errQ && !(ce && faultClr) |=> errQ)
        else $error("error flag cleared without fault clear");

    manual_done_a: assert property (
        ce && !startEv && !autoQ && stateQ == adc_seq_pkg::S_CONV && convDone
        |=> doneQ && resultQ == $past(convData))
        else $error("manual result not stored with done");

    manual_cov: cover property (ce && !autoQ && setDone);
    scan_cov:   cover property (ce && autoQ && setDone);
    error_cov:  cover property (ce && setErr);

endmodule : adc_sequencer
`default_nettype wire

// file: rtl/dim_period_meter.sv
// Measures the dimming period in core clock cycles between start pulses.
// Assumes the start pulse comes from the PWM generator on the same clock.
`timescale 1ns/1ps
`default_nettype none
module dim_period_meter (
    // Clock and reset
    input  wire logic                          clk_sys,
    input  wire logic                          reset_n,
    input  wire logic                          ce,
    // Dimming cycle marker
    input  wire logic                          dimCycleStart,
    // Measured period
    output logic [adc_seq_pkg::CYC_W-1:0]      period,
    output logic                               periodValid
);
    logic [adc_seq_pkg::CYC_W-1:0] cntQ;
    logic                          seenQ;
    wire                           cntMax = &cntQ;

    // Saturates so a stalled PWM reads as a very long period
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cntQ        <= '0;
            seenQ       <= 1'b0;
            period      <= '0;
            periodValid <= 1'b0;
        end else if (ce) begin
            if (dimCycleStart) begin
                cntQ        <= adc_seq_pkg::CYC_W'(1);
                seenQ       <= 1'b1;
                period      <= cntQ;
                periodValid <= seenQ;
            end else if (!cntMax) begin
                cntQ <= cntQ + adc_seq_pkg::CYC_W'(1);
            end
        end
    end
endmodule : dim_period_meter
`default_nettype wire
